/* File: dv/dma_channel_arm_request_ctrl_chk.sv */
// Port checker for the channel arm and request front end.
// Assumes one clock domain and a synchronous active high reset.
`timescale 1ns/1ps
module dma_channel_arm_request_ctrl_chk #(
	parameter int NCH = 5
) (
	// Clock and reset
	input wire logic                   sys_clk,
	input wire logic                   rst,
	// Register bus
	input wire dma_ctrl_pkg::sfr_req_t sfr,
	input wire logic [7:0]             sfr_rdata,
	// Descriptor fetch
	input wire logic                   mem_rd,
	input wire logic [15:0]            mem_addr,
	input wire logic                   mem_ack,
	// Channel events and state
	input wire logic [NCH-1:0]         ch_done,
	input wire logic [NCH-1:0]         ch_arm,
	input wire logic [NCH-1:0]         ch_ready,
	input wire logic [NCH-1:0]         ch_req,
	input wire logic [NCH-1:0]         ch_abort,
	input wire logic [NCH-1:0]         ch_repeat,
	input wire logic [NCH-1:0]         completion_flag
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	wire           arm_wr = sfr.wr && sfr.addr == dma_ctrl_pkg::OFF_ARM;
	wire           abort_wr = arm_wr && sfr.wdata[7];
	wire [NCH-1:0] wsel = sfr.wdata[NCH-1:0];
	wire [NCH-1:0] abort_sel = wsel & ch_arm;
	wire [NCH-1:0] done_once = ch_done & ~ch_repeat;
	wire [NCH-1:0] keep = ch_arm & ~done_once;
	wire           unmapped = sfr.addr < 8'hD2 || sfr.addr > 8'hD7;

	// ==========================================================
	// Assertions
	a_abort_pulse: assert property (
		abort_wr |=> ch_abort == $past(abort_sel))
		else $error("abort pulse does not match armed selection");
	a_abort_disarms: assert property (
		abort_wr |=> (ch_arm & $past(wsel)) == '0)
		else $error("aborted channel still armed");
	a_abort_reads_zero: assert property (
		sfr.rd && sfr.addr == dma_ctrl_pkg::OFF_ARM |=> !sfr_rdata[7])
		else $error("abort bit read back as one");
	a_work_needs_arm: assert property (
		((ch_req | ch_ready) & ~$past(ch_arm)) == '0)
		else $error("request or ready on unarmed channel");
	a_done_disarm: assert property (
		done_once != '0 && !arm_wr |=> (ch_arm & $past(done_once)) == '0)
		else $error("one shot channel stayed armed");
	a_arm_holds: assert property (
		!arm_wr |=> ($past(keep) & ~ch_arm) == '0)
		else $error("arm bit dropped without cause");
	a_done_flag: assert property (
		ch_done != '0 |=> (completion_flag & $past(ch_done)) == $past(ch_done))
		else $error("completion flag not set");
	a_unmapped_zero: assert property (
		sfr.rd && unmapped |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_fetch_hold: assert property (
		mem_rd && !mem_ack |=> mem_rd && $stable(mem_addr))
		else $error("fetch dropped or moved before ack");

	c_abort_armed: cover property (abort_wr && abort_sel != '0);
	c_done_once: cover property (done_once != '0);
	c_fetch_ack: cover property (mem_rd && mem_ack);
endmodule

bind dma_channel_arm_request_ctrl dma_channel_arm_request_ctrl_chk #(
	.NCH(NCH)
) u_chk (.sys_clk, .rst, .sfr, .sfr_rdata, .mem_rd, .mem_addr, .mem_ack,
	.ch_done, .ch_arm, .ch_ready, .ch_req, .ch_abort, .ch_repeat,
	.completion_flag);

/* File: dv/dma_channel_arm_request_ctrl_test.sv */
// Self-checking bench for the channel arm and request front end.
// Assumes the descriptor memory model and the bound port checker.
`timescale 1ns/1ps
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
	fails++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module dma_channel_arm_request_ctrl_test;
	localparam int NCH = 5;
	logic                   sys_clk, rst, mem_rd, mem_ack, slow;
	dma_ctrl_pkg::sfr_req_t sfr;
	logic [7:0]             sfr_rdata, mem_rdata, len_byte, var_len;
	logic [15:0]            mem_addr;
	logic [2:0]             len_ch;
	logic [NCH-1:0]         hw_trigger_select, ch_grant, ch_done, arb_try, flag_clr;
	logic [NCH-1:0]         ch_arm, ch_ready, ch_req, ch_abort;
	logic [NCH-1:0]         ch_repeat, ch_word, dma_first, completion_flag;
	int                     fails, cmp_count, cyc, seed;

	dma_channel_arm_request_ctrl #(.NCH(NCH)) i_dma_channel_arm_request_ctrl (
		.sys_clk, .rst, .sfr, .sfr_rdata, .mem_rd, .mem_addr, .mem_ack,
		.mem_rdata, .hw_trigger_select, .ch_grant, .ch_done, .arb_try, .flag_clr,
		.len_ch, .len_byte, .ch_arm, .ch_ready, .ch_req, .ch_abort,
		.ch_repeat, .ch_word, .dma_first, .completion_flag, .var_len);
	dma_desc_mem i_dma_desc_mem (.sys_clk, .rst, .mem_rd, .mem_addr,
		.mem_ack, .mem_rdata, .slow);

	// ==========================================================
	// Clock, timeout and verdict
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (fails == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Bus and event drivers
	task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(posedge sys_clk);
		sfr <= '{addr: a, wr: w, rd: !w, wdata: d};
		@(posedge sys_clk);
		sfr <= '0;
		#1;
	endtask
	task automatic pulse(input int k, input int c);
		@(posedge sys_clk);
		case (k)
		0: ch_grant <= 5'h01 << c;
		1: ch_done <= 5'h01 << c;
		2: arb_try <= 5'h01 << c;
		3: flag_clr <= 5'h01 << c;
		default: hw_trigger_select <= 5'h01 << c;
		endcase
		@(posedge sys_clk);
		{ch_grant, ch_done, arb_try, flag_clr, hw_trigger_select} <= '0;
		#1;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		logic [7:0]  ptr [4];
		logic [7:0]  b6, b7, exp;
		logic [15:0] base;
		{sfr, slow, hw_trigger_select, ch_grant, ch_done, arb_try, flag_clr} = '0;
		{len_ch, len_byte} = '0;
		rst = 1'b1;
		seed = 32'hab4bac45;
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		acc(8'hD1, 1'b1, 8'hFF);
		for (int a = 8'hD1; a <= 8'hD7; a++) begin
			acc(a[7:0], 1'b0, 8'h00);
			`CHK("reset", 8'h00, sfr_rdata)
		end
		acc(8'hD6, 1'b1, 8'hE0);
		acc(8'hD6, 1'b0, 8'h00);
		`CHK("arm_rd", 8'h60, sfr_rdata)
		// Low bytes kept small so descriptor bytes stay in one page
		for (int i = 0; i < 4; i++) begin
			ptr[i] = $random(seed) & (i[0] ? 8'hFF : 8'h7F);
			acc(8'hD2 + i[7:0], 1'b1, ptr[i]);
		end
		for (int i = 0; i < 4; i++) begin
			acc(8'hD2 + i[7:0], 1'b0, 8'h00);
			`CHK("pointer", ptr[i], sfr_rdata)
		end
		for (int c = 0; c < NCH; c++) begin
			base = c == 0 ? {ptr[3], ptr[2]} : {ptr[1], ptr[0]};
			if (c > 0)
				base = base + 16'(8 * (c - 1));
			// Odd channels start only by soft request, even ones also
			// by a routed trigger; the reserved priority is never used
			b6 = {1'($random(seed)), c[1:0], (c[0] ? 5'h00 : 5'h02)};
			b7 = {5'($random(seed)), 1'($random(seed)), 2'(c % 3)};
			i_dma_desc_mem.mem[base[7:0] + 8'h06] = b6 ^ base[15:8];
			i_dma_desc_mem.mem[base[7:0] + 8'h07] = b7 ^ base[15:8];
			slow <= 1'($random(seed));
			acc(8'hD6, 1'b1, 8'h01 << c);
			for (int i = 0; i < 40 && ch_ready[c] !== 1'b1; i++) begin
				@(posedge sys_clk);
				#1;
			end
			`CHK("ready", 1'b1, ch_ready[c])
			`CHK("repeat", b6[6], ch_repeat[c])
			`CHK("word", b6[7], ch_word[c])
			@(posedge sys_clk);
			len_ch <= c[2:0];
			len_byte <= $random(seed);
			settle(2);
			exp = (!b6[7] && b7[2]) ? {1'b0, len_byte[6:0]} : len_byte;
			`CHK("var_len", exp, var_len)
			`CHK("first", b7[1], dma_first[c])
			pulse(2, c);
			settle(1);
			`CHK("first", b7[1] | b7[0], dma_first[c])
			acc(8'hD7, 1'b1, 8'h01 << c);
			settle(1);
			`CHK("req", 1'b1, ch_req[c])
			acc(8'hD7, 1'b1, 8'h00);
			acc(8'hD7, 1'b0, 8'h00);
			`CHK("soft", 8'h01 << c, sfr_rdata)
			pulse(0, c);
			acc(8'hD7, 1'b0, 8'h00);
			`CHK("soft", 8'h00, sfr_rdata)
			`CHK("arm", 1'b1, ch_arm[c])
			pulse(4, c);
			settle(1);
			`CHK("trigger_select", !c[0], ch_req[c])
			pulse(0, c);
			settle(1);
			`CHK("req", 1'b0, ch_req[c])
			pulse(1, c);
			settle(1);
			`CHK("flag", 1'b1, completion_flag[c])
			`CHK("arm", b6[6], ch_arm[c])
			acc(8'hD6, 1'b1, 8'h80 | (8'h01 << c));
			`CHK("abort", b6[6], ch_abort[c])
			`CHK("arm", 1'b0, ch_arm[c])
			acc(8'hD6, 1'b0, 8'h00);
			`CHK("arm_rd", 8'h00, sfr_rdata)
			pulse(3, c);
			settle(1);
			`CHK("flag", 1'b0, completion_flag[c])
		end
		tally_and_finish();
	end
endmodule

/* File: dv/dma_desc_mem.sv */
// Descriptor memory model answering fetch reads after 0 or 3 waits.
// Assumes one read at a time, held by the requester until acked.
`timescale 1ns/1ps
module dma_desc_mem (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Fetch port
	input  wire logic        mem_rd,
	input  wire logic [15:0] mem_addr,
	output logic             mem_ack,
	output logic [7:0]       mem_rdata,
	// Answer speed
	input  wire logic        slow
);
	logic [7:0] mem [256];
	logic [1:0] wait_r;

	// Data toggles outside acks so a stale byte never looks valid
	always_ff @(posedge sys_clk) begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (rst) begin
			wait_r <= 2'h0;
		end else if (mem_rd && !mem_ack) begin
			if (!slow || wait_r == 2'h3) begin
				mem_ack <= 1'b1;
				mem_rdata <= mem[mem_addr[7:0]] ^ mem_addr[15:8];
				wait_r <= 2'h0;
			end else begin
				wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule

/* File: verilog/dma_channel_arm_request_ctrl.sv */
// Channel arm, abort, soft request and descriptor pointer logic of a
// five-channel DMA controller. Assumes a CPU on the 8-bit register bus,
// a byte memory port with an ack, and a data mover that reports grant,
// completion and arbitration attempts per channel on sys_clk.
`timescale 1ns/1ps

module dma_channel_arm_request_ctrl #(
	parameter int NCH = 5
) (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	// Register bus
	input  wire dma_ctrl_pkg::sfr_req_t sfr,
	output logic [7:0]                  sfr_rdata,
	// Descriptor fetch port
	output logic                        mem_rd,
	output logic [15:0]                 mem_addr,
	input  wire logic                   mem_ack,
	input  wire logic [7:0]             mem_rdata,
	// Data mover events
	input  wire logic [NCH-1:0]         hw_trigger_select,
	input  wire logic [NCH-1:0]         ch_grant,
	input  wire logic [NCH-1:0]         ch_done,
	input  wire logic [NCH-1:0]         arb_try,
	input  wire logic [NCH-1:0]         flag_clr,
	// Length byte seen by the mover
	input  wire logic [2:0]             len_ch,
	input  wire logic [7:0]             len_byte,
	// Channel state towards the mover
	output logic [NCH-1:0]              ch_arm,
	output logic [NCH-1:0]              ch_ready,
	output logic [NCH-1:0]              ch_req,
	output logic [NCH-1:0]              ch_abort,
	output logic [NCH-1:0]              ch_repeat,
	output logic [NCH-1:0]              ch_word,
	output logic [NCH-1:0]              dma_first,
	output logic [NCH-1:0]              completion_flag,
	output logic [7:0]                  var_len
);

	// ==========================================================
	// Checks
	if (NCH < 1 || NCH > 5) begin : g_bad_nch
		$error("NCH must lie between 1 and 5");
	end

	// ==========================================================
	// Functions
	// Channel 0 descriptor at the first pointer, the rest consecutive from the shared pointer
	function automatic logic [15:0] desc_base(input logic [2:0] ch,
		input logic [15:0] first, input logic [15:0] shared);
		logic [15:0] idx;
		idx = {13'h0000, ch} - 16'h0001;
		if (ch == 3'h0)
			desc_base = first;
		else
			desc_base = shared + (idx << 3);
	endfunction

	function automatic logic [7:0] length_of(input logic [7:0] b,
		input logic m8, input logic word);
		if (!word && m8)
			length_of = {1'b0, b[dma_ctrl_pkg::LEN7_MSB:0]};
		else
			length_of = b;
	endfunction

	// ==========================================================
	// State
	logic [7:0]               first_lo_r, first_hi_r;
	logic [7:0]               shared_lo_r, shared_hi_r;
	logic [1:0]               spare_r;
	logic [NCH-1:0]           arm_r, arm_nxt;
	logic [NCH-1:0]           soft_r, soft_nxt;
	logic [NCH-1:0]           pend_r, pend_nxt;
	logic [NCH-1:0]           loaded_r, loaded_nxt;
	logic [NCH-1:0]           need_r, need_nxt;
	logic [NCH-1:0]           alt_r;
	logic [NCH-1:0]           flag_r;
	logic [NCH-1:0]           abort_r, abort_nxt;
	logic [NCH-1:0]           req_r, ready_r, rep_r, word_r, first_r;
	logic [NCH-1:0]           evt;
	dma_ctrl_pkg::desc_t      desc_r [NCH];
	dma_ctrl_pkg::fetch_state_t fst_r;
	logic [2:0]               cur_r;
	logic                     idx_r, mem_rd_r;
	logic [15:0]              mem_addr_r;
	logic [7:0]               rdata_r, len_r;

	// ==========================================================
	// Decode
	wire        wr_arm    = sfr.wr && sfr.addr == dma_ctrl_pkg::OFF_ARM;
	wire        wr_req    = sfr.wr && sfr.addr == dma_ctrl_pkg::OFF_SOFT_REQ;
	wire        abort_wr  = wr_arm && sfr.wdata[dma_ctrl_pkg::ARM_ABORT_BIT];
	wire [15:0] first_ptr = {first_hi_r, first_lo_r};
	wire [15:0] shared_ptr = {shared_hi_r, shared_lo_r};
	wire        fetch_ok  = fst_r == dma_ctrl_pkg::F_READ && mem_ack;

	logic [2:0] pick;
	logic       pick_any;
	always_comb begin
		pick = 3'h0;
		pick_any = 1'b0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (need_r[i]) begin
				pick = 3'(i);
				pick_any = 1'b1;
			end
		end
	end

	// ==========================================================
	// Per-channel next state
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			// Repeated modes have the upper mode bit set
			logic rep;
			logic [4:0] tsel;
			rep = desc_r[i].transfer_pattern[1];
			tsel = desc_r[i].trigger_select;
			if (tsel == dma_ctrl_pkg::TRIGGER_SELECT_NONE)
				evt[i] = 1'b0;
			else if (tsel == dma_ctrl_pkg::TRIGGER_SELECT_PREV)
				evt[i] = (i > 0) ? ch_done[(i > 0) ? i - 1 : 0] : 1'b0;
			else
				evt[i] = hw_trigger_select[i];

			abort_nxt[i] = abort_wr && sfr.wdata[i] && arm_r[i];
			if (wr_arm) begin
				if (abort_wr)
					arm_nxt[i] = arm_r[i] && !sfr.wdata[i];
				else
					arm_nxt[i] = sfr.wdata[i];
			end else if (ch_done[i] && !rep) begin
				arm_nxt[i] = 1'b0;
			end else begin
				arm_nxt[i] = arm_r[i];
			end

			need_nxt[i] = arm_nxt[i] &&
				((need_r[i] && !(fetch_ok && idx_r && cur_r == 3'(i)))
				|| !arm_r[i]);
			loaded_nxt[i] = arm_nxt[i] && arm_r[i] && (loaded_r[i] ||
				(fetch_ok && idx_r && cur_r == 3'(i)));

			// Soft request is one trigger; grant clears it
			soft_nxt[i] = (wr_req && sfr.wdata[i]) ||
				(soft_r[i] && !ch_grant[i]);
			pend_nxt[i] = (evt[i] && arm_r[i] && loaded_r[i]) ||
				(pend_r[i] && !ch_grant[i]);
		end
	end

	// ==========================================================
	// Registers written by software
	// Pointer bytes reset to zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			{first_lo_r, first_hi_r, shared_lo_r, shared_hi_r} <=
				{4{dma_ctrl_pkg::RST_BYTE}};
			spare_r     <= 2'h0;
		end else if (sfr.wr) begin
			case (sfr.addr)
				dma_ctrl_pkg::OFF_FIRST_LO: first_lo_r <= sfr.wdata;
				dma_ctrl_pkg::OFF_FIRST_HI: first_hi_r <= sfr.wdata;
				dma_ctrl_pkg::OFF_SHARED_LO: shared_lo_r <= sfr.wdata;
				dma_ctrl_pkg::OFF_SHARED_HI: shared_hi_r <= sfr.wdata;
				dma_ctrl_pkg::OFF_ARM: spare_r <= sfr.wdata[
					dma_ctrl_pkg::ARM_SPARE_MSB:dma_ctrl_pkg::ARM_SPARE_LSB];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Channel state
	// Arm bits reset to zero; a disarm write, an abort or a one-shot completion stops a channel
	always_ff @(posedge sys_clk) begin
		if (rst)
			{arm_r, soft_r, pend_r, need_r, loaded_r, abort_r} <= '0;
		else
			{arm_r, soft_r, pend_r, need_r, loaded_r, abort_r} <=
				{arm_nxt, soft_nxt, pend_nxt,
				need_nxt, loaded_nxt, abort_nxt};
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			{flag_r, alt_r} <= '0;
		end else begin
			// Completion flag, set wins over clear
			flag_r <= ch_done | (flag_r & ~flag_clr);
			alt_r  <= alt_r ^ arb_try;
		end
	end

	// ==========================================================
	// Outputs towards the mover, all registered
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			{req_r, ready_r, rep_r, word_r, first_r} <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				// Requests only reach the mover when armed
				req_r[i]   <= arm_nxt[i] && loaded_nxt[i] &&
					(soft_nxt[i] || pend_nxt[i]);
				ready_r[i] <= arm_nxt[i] && loaded_nxt[i];
				rep_r[i]   <= desc_r[i].transfer_pattern[1];
				word_r[i]  <= desc_r[i].word_transfer_select;
				case (desc_r[i].priority_code)
					dma_ctrl_pkg::PRIO_LOW:  first_r[i] <= 1'b0;
					dma_ctrl_pkg::PRIO_GUAR: first_r[i] <= alt_r[i];
					default:                 first_r[i] <= 1'b1;
				endcase
			end
		end
	end

	// ==========================================================
	// Descriptor fetch
	// Only bytes six and seven are kept; the rest belongs to the mover.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fst_r      <= dma_ctrl_pkg::F_IDLE;
			{cur_r, idx_r, mem_rd_r} <= '0;
			mem_addr_r <= dma_ctrl_pkg::RST_PTR;
			for (int i = 0; i < NCH; i++)
				desc_r[i] <= '0;
		end else begin
			case (fst_r)
				dma_ctrl_pkg::F_IDLE: begin
					if (pick_any) begin
						cur_r      <= pick;
						idx_r      <= 1'b0;
						mem_rd_r   <= 1'b1;
						mem_addr_r <= desc_base(pick, first_ptr,
							shared_ptr) + dma_ctrl_pkg::DESC_MODE_BYTE;
						fst_r      <= dma_ctrl_pkg::F_READ;
					end
				end
				dma_ctrl_pkg::F_READ: begin
					if (mem_ack) begin
						if (!idx_r) begin
							desc_r[cur_r].word_transfer_select <=
								mem_rdata[dma_ctrl_pkg::D6_WORD_BIT];
							desc_r[cur_r].transfer_pattern <=
								mem_rdata[dma_ctrl_pkg::D6_MODE_LSB+:2];
							desc_r[cur_r].trigger_select <= mem_rdata[4:0];
							idx_r      <= 1'b1;
							mem_addr_r <= mem_addr_r + 16'h0001;
						end else begin
							desc_r[cur_r].variable_length_mode <=
								mem_rdata[dma_ctrl_pkg::D7_M8_BIT];
							desc_r[cur_r].priority_code <= mem_rdata[1:0];
							mem_rd_r <= 1'b0;
							fst_r    <= dma_ctrl_pkg::F_IDLE;
						end
					end
				end
				default: begin
					mem_rd_r <= 1'b0;
					fst_r    <= dma_ctrl_pkg::F_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Length and read data
	wire [2:0] lsel = (len_ch < 3'(NCH)) ? len_ch : 3'h0;

	always_ff @(posedge sys_clk) begin
		if (rst)
			len_r <= 8'h00;
		else
			len_r <= length_of(len_byte,
				desc_r[lsel].variable_length_mode,
				desc_r[lsel].word_transfer_select);
	end

	wire [7:0] arm_pad = {1'b0, spare_r, 5'(arm_r)};
	wire [7:0] req_pad = 8'(soft_r);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_r <= 8'h00;
		end else if (sfr.rd) begin
			case (sfr.addr)
				dma_ctrl_pkg::OFF_FIRST_LO:  rdata_r <= first_lo_r;
				dma_ctrl_pkg::OFF_FIRST_HI:  rdata_r <= first_hi_r;
				dma_ctrl_pkg::OFF_SHARED_LO: rdata_r <= shared_lo_r;
				dma_ctrl_pkg::OFF_SHARED_HI: rdata_r <= shared_hi_r;
				dma_ctrl_pkg::OFF_ARM:       rdata_r <= arm_pad;
				dma_ctrl_pkg::OFF_SOFT_REQ:  rdata_r <= req_pad;
				default:                     rdata_r <= 8'h00;
			endcase
		end
	end

	// ==========================================================
	// Port drive
	assign sfr_rdata = rdata_r;
	assign {mem_rd, mem_addr} = {mem_rd_r, mem_addr_r};
	assign {ch_arm, ch_ready, ch_req} = {arm_r, ready_r, req_r};
	assign {ch_abort, ch_repeat, ch_word} = {abort_r, rep_r, word_r};
	assign {dma_first, completion_flag} = {first_r, flag_r};
	assign var_len = len_r;

endmodule

/* File: verilog/dma_ctrl_pkg.sv */
// Constants, field layouts and carriers for the DMA channel control front end.
// Assumes an 8-bit register bus and a byte-wide descriptor memory port.
package dma_ctrl_pkg;

	// ==========================================================
	// Register offsets and reset values
	localparam logic [7:0] OFF_SHARED_LO = 8'hD2;
	localparam logic [7:0] OFF_SHARED_HI = 8'hD3;
	localparam logic [7:0] OFF_FIRST_LO  = 8'hD4;
	localparam logic [7:0] OFF_FIRST_HI  = 8'hD5;
	localparam logic [7:0] OFF_ARM       = 8'hD6;
	localparam logic [7:0] OFF_SOFT_REQ  = 8'hD7;
	localparam logic [7:0] RST_BYTE      = 8'h00;

	// ==========================================================
	// Field positions
	localparam int ARM_ABORT_BIT  = 7;
	localparam int ARM_SPARE_LSB  = 5;
	localparam int ARM_SPARE_MSB  = 6;
	localparam int D6_WORD_BIT    = 7;
	localparam int D6_MODE_LSB    = 5;
	localparam int D7_M8_BIT      = 2;
	localparam int LEN7_MSB       = 6;

	// ==========================================================
	// Descriptor layout in memory
	localparam logic [15:0] DESC_SIZE      = 16'h0008;
	localparam logic [15:0] DESC_MODE_BYTE = 16'h0006;
	localparam logic [15:0] RST_PTR        = 16'h0000;

	// ==========================================================
	// Encodings
	localparam logic [1:0] PRIO_LOW  = 2'h0;
	localparam logic [1:0] PRIO_GUAR = 2'h1;
	localparam logic [1:0] PRIO_HIGH = 2'h2;
	localparam logic [1:0] MODE_SINGLE = 2'h0;
	localparam logic [1:0] MODE_BLOCK  = 2'h1;
	localparam logic [4:0] TRIGGER_SELECT_NONE = 5'h00;
	localparam logic [4:0] TRIGGER_SELECT_PREV = 5'h01;

	typedef enum logic [1:0] {
		F_IDLE = 2'b00,
		F_READ = 2'b01
	} fetch_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} sfr_req_t;

	typedef struct packed {
		logic       word_transfer_select;
		logic [1:0] transfer_pattern;
		logic [4:0] trigger_select;
		logic       variable_length_mode;
		logic [1:0] priority_code;
	} desc_t;

endpackage
